// File: design/rcdfr_top.sv
// reset cause register and debug forced reset control
// How it works
// - at each reset entry every flag whose source is active is set and all others cleared, unless a debug force write in the same cycle clears them all.
// - a reset forced by the debug host clears all cause flags.
// - any write to the cause register restarts the watchdog and leaves the flags alone.
// - power-on sets bit 7 and also the low-voltage bit 1.
// - an external pin reset sets bit 6.
// - a watchdog timeout sets bit 5, which cannot happen while the watchdog is disabled.
// - an illegal opcode, including disabled stop or background instructions, sets bit 4.
// - an access to an unimplemented address sets bit 3.
// - a low-voltage trip with its reset enabled resets the part and sets bit 1.
// - the force register is write-only with one bit and always reads zero.
// - user program writes to the force register are ignored; only debug writes count.
// - a debug write of one to bit 0 forces a complete reset, but only while no reset is in progress.
`default_nettype none
module rcdfr_top
  import rcdfr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic por_active,
  input wire logic ext_reset_n,
  input wire logic watchdog_timeout,
  input wire logic watchdog_enable,
  input wire logic illegal_opcode,
  input wire logic stop_exec,
  input wire logic stop_mode_enable,
  input wire logic bgnd_exec,
  input wire logic background_mode_enable,
  input wire logic illegal_address,
  input wire logic low_voltage_trip,
  input wire logic low_voltage_reset_enable,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [0:0] reg_sel,
  input wire logic reg_from_debug,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic watchdog_restart,
  output logic system_reset_req,
  output logic forced_reset
);
  // ------------------------------------------------------------
  // source qualification
  // ------------------------------------------------------------
  rcdfr_src_if src();
  rcdfr_state_type state;
  rcdfr_state_type next_state;
  logic [3:0] hold_cnt;
  logic [3:0] next_hold_cnt;
  logic [7:0] rdata;
  logic wd_restart;

  wire logic wdog_src = watchdog_timeout & watchdog_enable;
  wire logic illegal_opcode_flag_src = illegal_opcode | (stop_exec & ~stop_mode_enable) |
                        (bgnd_exec & ~background_mode_enable);
  wire logic lvd_src = low_voltage_trip & low_voltage_reset_enable;
  wire logic pin_src = ~ext_reset_n;
  wire logic any_src = por_active | pin_src | wdog_src | illegal_opcode_flag_src | illegal_address | lvd_src;
  wire logic wr_flags = reg_wr & (reg_sel == rcdfr_sel_flags);
  // user writes never reach the force bit
  wire logic wr_force = reg_wr & (reg_sel == rcdfr_sel_force) & reg_from_debug;
  wire logic force_go = wr_force & reg_wdata[rcdfr_bit_force] & (state == rcdfr_run);

  assign src.por = por_active;
  assign src.pin = pin_src;
  assign src.wdog = wdog_src;
  assign src.illegal_opcode_flag = illegal_opcode_flag_src;
  assign src.illegal_address_flag = illegal_address;
  assign src.low_voltage_trip_flag = lvd_src;
  // capture only on the run-to-reset transition
  assign src.entry = (state == rcdfr_run) & any_src;
  assign src.clear_all = force_go;

  rcdfr_cause_latch u_latch (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .src(src)
  );

  // ------------------------------------------------------------
  // reset sequencing
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    case (state)
      rcdfr_run: begin
        if (src.entry) begin
          next_state = rcdfr_in_reset;
        end else if (force_go) begin
          next_state = rcdfr_forcing;
          next_hold_cnt = rcdfr_force_hold;
        end
      end
      rcdfr_in_reset: begin
        // stay until every source has gone away
        if (!any_src) begin
          next_state = rcdfr_run;
        end
      end
      rcdfr_forcing: begin
        if (hold_cnt == 4'h1) begin
          next_state = rcdfr_run;
        end
        next_hold_cnt = hold_cnt - 4'h1;
      end
      default: begin
        next_state = rcdfr_run;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rcdfr_run;
      hold_cnt <= 4'h0;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  wire logic [7:0] next_rdata = (reg_sel == rcdfr_sel_flags) ? src.flags :
                                rcdfr_force_read;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      wd_restart <= 1'b0;
    end else begin
      rdata <= reg_rd ? next_rdata : 8'h00;
      wd_restart <= wr_flags;
    end
  end

  assign reg_rdata = rdata;
  assign watchdog_restart = wd_restart;
  assign system_reset_req = (state != rcdfr_run);
  assign forced_reset = (state == rcdfr_forcing);
endmodule // rcdfr_top
`default_nettype wire

// File: inc/rcdfr_pkg.sv
// constants and types for the reset cause and debug forced reset block
`default_nettype none
package rcdfr_pkg;
  localparam int unsigned rcdfr_data_w = 8;
  // register select codes on the internal register port
  localparam logic [0:0] rcdfr_sel_flags = 1'h0;
  localparam logic [0:0] rcdfr_sel_force = 1'h1;
  // flag positions
  localparam int unsigned rcdfr_bit_por = 7;
  localparam int unsigned rcdfr_bit_pin = 6;
  localparam int unsigned rcdfr_bit_wdog = 5;
  localparam int unsigned rcdfr_bit_illegal_opcode_flag = 4;
  localparam int unsigned rcdfr_bit_illegal_address_flag = 3;
  localparam int unsigned rcdfr_bit_lvd = 1;
  localparam int unsigned rcdfr_bit_force = 0;
  localparam logic [7:0] rcdfr_flags_reset = 8'h00;
  localparam logic [7:0] rcdfr_force_read = 8'h00;
  // cycles the internal forced reset request is held
  localparam logic [3:0] rcdfr_force_hold = 4'h4;
  typedef enum logic [1:0] {rcdfr_run, rcdfr_in_reset, rcdfr_forcing} rcdfr_state_type;
endpackage
`default_nettype wire

// File: inc/rcdfr_src_if.sv
// reset source bundle passed from the top to the cause latch
`default_nettype none
interface rcdfr_src_if;
  logic por;
  logic pin;
  logic wdog;
  logic illegal_opcode_flag;
  logic illegal_address_flag;
  logic low_voltage_trip_flag;
  logic entry;
  logic clear_all;
  logic [7:0] flags;
  modport top (output por, pin, wdog, illegal_opcode_flag, illegal_address_flag, low_voltage_trip_flag, entry, clear_all, input flags);
  modport latch (input por, pin, wdog, illegal_opcode_flag, illegal_address_flag, low_voltage_trip_flag, entry, clear_all, output flags);
endinterface
`default_nettype wire

// File: design/rcdfr_cause_latch.sv
// cause flag capture register
`default_nettype none
module rcdfr_cause_latch
  import rcdfr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  rcdfr_src_if.latch src
);
  logic [7:0] flags;
  wire logic [7:0] captured;
  wire logic [7:0] next_flags;

  assign captured = {src.por, src.pin, src.wdog, src.illegal_opcode_flag, src.illegal_address_flag, 1'b0,
                     src.low_voltage_trip_flag | src.por, 1'b0};
  // forced reset wins: the host asked for a clean slate
  assign next_flags = src.clear_all ? rcdfr_flags_reset :
                      src.entry ? captured : flags;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= rcdfr_flags_reset;
    end else begin
      flags <= next_flags;
    end
  end

  assign src.flags = flags;
endmodule // rcdfr_cause_latch
`default_nettype wire

// File: testbench/rcdfr_chk.sv
// port assertions for the reset cause block
`default_nettype none
module rcdfr_chk(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic por_active,
  input wire logic ext_reset_n,
  input wire logic illegal_address,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [0:0] reg_sel,
  input wire logic reg_from_debug,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic watchdog_restart,
  input wire logic system_reset_req,
  input wire logic forced_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic flags_wr = reg_wr && reg_sel == 1'h0;
  wire logic force_wr = reg_wr && reg_sel == 1'h1 && reg_from_debug && reg_wdata[0];
  wire logic src_on = por_active || !ext_reset_n || illegal_address;
  sequence s_hold;
    forced_reset [*4] ##1 !forced_reset;
  endsequence
  AST_ENTRY: assert property (!system_reset_req && src_on |=> system_reset_req)
    else $error("no reset entry");
  AST_PIN_HOLD: assert property (system_reset_req && !ext_reset_n |=> system_reset_req)
    else $error("pin reset dropped");
  AST_RESTART: assert property (flags_wr |=> watchdog_restart)
    else $error("no restart");
  AST_NO_RESTART: assert property (!flags_wr |=> !watchdog_restart)
    else $error("stray restart");
  AST_FORCE: assert property (force_wr && !system_reset_req |=> s_hold)
    else $error("bad force hold");
  AST_FORCE_SRC: assert property ($rose(forced_reset) |-> $past(force_wr))
    else $error("force not from debug");
  AST_FORCE_REQ: assert property (forced_reset |-> system_reset_req)
    else $error("force without reset");
  AST_FORCE_RD: assert property (reg_rd && reg_sel == 1'h1 |=> reg_rdata == 8'h00)
    else $error("force reg read nonzero");
endmodule // rcdfr_chk
`default_nettype wire

// File: testbench/rcdfr_host.sv
// debug host model on the register port
`default_nettype none
module rcdfr_host(
  input wire logic ref_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [0:0] reg_sel,
  output logic reg_from_debug,
  output logic [7:0] reg_wdata,
  output logic mode_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_wr, reg_rd, reg_sel, reg_from_debug, reg_wdata, mode_pin} = 13'h1;
  task automatic wr(input logic s, input logic d, input logic [7:0] v);
    @(posedge ref_clk) #1 {reg_wr, reg_sel, reg_from_debug, reg_wdata} = {1'h1, s, d, v};
    @(posedge ref_clk) #1 reg_wr = 1'h0;
    reg_wdata = ~v; // released data must not look held
    if (s && d && v[0]) mode_pin = 1'h1; // high right after forcing: user mode
  endtask
  task automatic rd(input logic s);
    @(posedge ref_clk) #1 {reg_rd, reg_sel} = {1'h1, s};
    @(posedge ref_clk) #1 reg_rd = 1'h0;
  endtask
endmodule // rcdfr_host
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the reset cause block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic por_active, ext_reset_n, watchdog_timeout, watchdog_enable, illegal_opcode, stop_exec;
  logic stop_mode_enable, bgnd_exec, background_mode_enable, illegal_address;
  logic low_voltage_trip, low_voltage_reset_enable, reg_wr, reg_rd, reg_from_debug;
  logic [0:0] reg_sel;
  logic [7:0] reg_wdata, reg_rdata;
  logic watchdog_restart, system_reset_req, forced_reset;
  logic [11:0] src = 12'h529;
  int n_fail = 0;
  int samples_checked = 0;
  // rows: source vector, expected flags
  // blocked sources follow a different cause so a wrongly taken reset shows up
  logic [19:0] rows [11] = '{20'hd2982, 20'h5a910, 20'h12940, 20'h62940,
    20'h72920, 20'h54910, 20'h52d08, 20'h52a08,
    20'h52b02, 20'h53110, 20'h12d48};
  assign {por_active, ext_reset_n, watchdog_timeout, watchdog_enable, illegal_opcode,
    stop_exec, stop_mode_enable, bgnd_exec, background_mode_enable, illegal_address,
    low_voltage_trip, low_voltage_reset_enable} = src;
  always #2 ref_clk = ~ref_clk;
  rcdfr_top DUT(.*);
  rcdfr_host host(.*, .mode_pin());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rflag(input logic [7:0] e);
    host.rd(1'h0);
    chk(reg_rdata, e);
  endtask
  task automatic settle;
    repeat (40) if (system_reset_req !== 1'h0) @(posedge ref_clk) #1;
  endtask
  task automatic test_done;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'h1;
    rflag(8'h00);
    foreach (rows[i]) begin
      @(posedge ref_clk) #1 src = rows[i][19:8];
      repeat (2) @(posedge ref_clk);
      #1 src = 12'h529;
      settle;
      rflag(rows[i][7:0]);
    end
    host.wr(1'h0, 1'h0, 8'hff);
    chk({7'h0, watchdog_restart}, 8'h01);
    rflag(8'h48);
    rflag(8'h48);
    host.wr(1'h1, 1'h0, 8'h01);
    chk({6'h0, watchdog_restart, forced_reset}, 8'h00);
    host.wr(1'h1, 1'h1, 8'hfe);
    chk({6'h0, system_reset_req, forced_reset}, 8'h00);
    host.rd(1'h1);
    chk(reg_rdata, 8'h00);
    host.wr(1'h1, 1'h1, 8'h01);
    chk({6'h0, system_reset_req, forced_reset}, 8'h03);
    settle;
    rflag(8'h00);
    test_done;
  end
  // whole run needs about a hundred cycles
  initial begin
    #20000;
    n_fail++;
    test_done;
  end
endmodule // tb
bind rcdfr_top rcdfr_chk u_chk(.*);
`default_nettype wire
